// >>> hdl/port_seq_pkg.sv
package port_seq_pkg;

    // Time base
    localparam int unsigned CLK_KHZ       = 250000;

    // Times in their own units
    localparam int unsigned T_RST_SHORT_MS = 400;
    localparam int unsigned T_RST_LONG_S   = 2;
    localparam int unsigned T_DIS_MAX_S    = 2;
    localparam int unsigned T_DETACH_MS    = 675;
    localparam int unsigned T_DSW_ON_US    = 800;
    localparam int unsigned T_PG_OV_US     = 100;
    localparam int unsigned T_SW_OV_US     = 5;

    // Derived cycle counts
    localparam int unsigned C_RST_SHORT = T_RST_SHORT_MS * CLK_KHZ;
    localparam int unsigned C_RST_LONG  = T_RST_LONG_S * CLK_KHZ * 1000;
    localparam int unsigned C_DIS_MAX   = T_DIS_MAX_S * CLK_KHZ * 1000;
    localparam int unsigned C_DETACH    = T_DETACH_MS * CLK_KHZ;
    localparam int unsigned C_DSW_ON    = (T_DSW_ON_US * CLK_KHZ + 999) / 1000;
    localparam int unsigned C_PG_OV     = (T_PG_OV_US * CLK_KHZ + 999) / 1000;
    localparam logic [31:0] C_SW_OV     = 32'((T_SW_OV_US * CLK_KHZ + 999) / 1000);

    // Charging mode encoding
    localparam logic [1:0] MODE_STD = 2'h0;  // Standard downstream port
    localparam logic [1:0] MODE_CDN = 2'h1;  // Charging downstream port
    localparam logic [1:0] MODE_DED = 2'h2;  // Dedicated charging port

    // Bit positions inside the synchroniser vector
    localparam int IN_EN   = 0;
    localparam int IN_POR  = 1;
    localparam int IN_FB   = 2;
    localparam int IN_SAFE = 3;
    localparam int IN_OT   = 4;
    localparam int IN_RD1  = 5;
    localparam int IN_RD2  = 6;
    localparam int IN_OV1  = 7;
    localparam int IN_OV2  = 8;
    localparam int IN_DSP  = 9;
    localparam int IN_DSM  = 10;
    localparam int IN_M0   = 11;
    localparam int IN_W    = 13;

    // Value of the input-fill counter once synchronisers hold real data
    localparam logic [1:0] FILL_DONE = 2'h3;

    // VBUS reset sequencer
    typedef enum logic [1:0] {
        RS_IDLE  = 2'b00,
        RS_DISCH = 2'b01,
        RS_HOLD  = 2'b11
    } rs_state_type;

    // Type-C port state
    typedef enum logic [1:0] {
        TC_UNATT  = 2'b00,
        TC_ATT    = 2'b01,
        TC_DETACH = 2'b11,
        TC_OV     = 2'b10
    } tc_state_type;

    // All state of the sequencer
    typedef struct packed {
        logic [IN_W-1:0] s1;
        logic [IN_W-1:0] s2;
        logic [1:0]      fill;
        logic [1:0]      mode_prev;
        rs_state_type    rs;
        logic [31:0]     rs_tmr;
        logic [31:0]     rs_len;
        tc_state_type    tc;
        logic            tc_sel;
        logic [31:0]     tc_tmr;
        logic            sw_blk;
        logic [31:0]     sw_tmr;
        logic            pg_blk;
        logic [31:0]     pg_tmr;
        logic            por_rdy;
        logic [31:0]     por_tmr;
        logic            conv_en;
        logic            ss_pull;
        logic            vbus_dis;
        logic            pwr_ok;
        logic            dsw_on;
        logic            gate_on;
        logic            cc1_pu;
        logic            cc2_pu;
    } seq_state_type;

endpackage

// >>> hdl/usb_port_power_sequencer.sv
// Summary of operation
// - Over-temperature stops switching, restarts with soft-start
// - Mode change activates reset discharge pin
// - Reset: converter off, discharge, then restart
// - Discharge phase bounded by 2 s timeout
// - Reset lasts 400 ms or 2 s
// - Power-ok rising edge starts 400 ms reset
// - Standard or charging-downstream mode closes switch
// - Switch closes 800 us after bias POR
// - Switch opens when bias drops to POR
// - Data over-voltage: switch 5 us, power-ok 100 us
// - Recovery: power-ok 100 us, switch 5 us
// - Power-ok rise after data fault resets VBUS
// - Downstream only; attach on either CC line
// - Attach turns on VBUS gate within 150 ms
// - Detach opens CC, waits vSafe0V, re-pulls up
// - Detach wait capped at 675 ms
// - CC over-voltage drops power-ok and gate
// - CC over-voltage discharges VBUS within 35 ms
// - CC fault removal restores power-ok, awaits attach
// - Any protection holds power-ok low
module usb_port_power_sequencer #(
    parameter int unsigned C_RST_SHORT = port_seq_pkg::C_RST_SHORT,
    parameter int unsigned C_RST_LONG  = port_seq_pkg::C_RST_LONG,
    parameter int unsigned C_DIS_MAX   = port_seq_pkg::C_DIS_MAX,
    parameter int unsigned C_DETACH    = port_seq_pkg::C_DETACH,
    parameter int unsigned C_DSW_ON    = port_seq_pkg::C_DSW_ON,
    parameter int unsigned C_PG_OV     = port_seq_pkg::C_PG_OV
) (
    input  wire logic       clk_sys,
    input  wire logic       rst,
    input  wire logic       enable,
    input  wire logic       bias_por_ok,
    input  wire logic       power_ok_rise_threshold,
    input  wire logic       vbus_sense_pin,
    input  wire logic       over_temp,
    input  wire logic       cc1_sink_seen,
    input  wire logic       cc2_sink_seen,
    input  wire logic       cc1_over_volt,
    input  wire logic       cc2_over_volt,
    input  wire logic       data_side_plus,
    input  wire logic       data_side_minus,
    input  wire logic [1:0] charging_mode_select,
    output logic            converter_on,
    output logic            reset_discharge,
    output logic            vbus_discharge,
    output logic            power_ok_output,
    output logic            data_switch_on,
    output logic            vbus_gate_on,
    output logic            cc1_pullup_on,
    output logic            cc2_pullup_on
);

    // Whole state and its next value
    port_seq_pkg::seq_state_type st_r;
    port_seq_pkg::seq_state_type st_nxt;

    // Raw pins gathered for the synchroniser
    logic [port_seq_pkg::IN_W-1:0] pins;

    // Synchronised views, all from the second stage
    logic       en_s;
    logic       por_s;
    logic       fb_s;
    logic       safe_s;
    logic       ot_s;
    logic       rd1_s;
    logic       rd2_s;
    logic       ccov_s;
    logic       dsov_s;
    logic [1:0] mode_s;

    // Combinational helpers
    logic       rd_sel;     // Sink still seen on the attached line
    logic       pg_want;    // Power-ok level before registering
    logic       rs_go;      // Start a VBUS reset this cycle
    logic [31:0] rs_len_go; // Length of that reset
    logic       mode_chg;   // Charging mode changed

    assign pins = {charging_mode_select, data_side_minus, data_side_plus,
                   cc2_over_volt, cc1_over_volt, cc2_sink_seen, cc1_sink_seen,
                   over_temp, vbus_sense_pin, power_ok_rise_threshold,
                   bias_por_ok, enable};

    assign en_s   = st_r.s2[port_seq_pkg::IN_EN];
    assign por_s  = st_r.s2[port_seq_pkg::IN_POR];
    assign fb_s   = st_r.s2[port_seq_pkg::IN_FB];
    assign safe_s = st_r.s2[port_seq_pkg::IN_SAFE];
    assign ot_s   = st_r.s2[port_seq_pkg::IN_OT];
    assign rd1_s  = st_r.s2[port_seq_pkg::IN_RD1];
    assign rd2_s  = st_r.s2[port_seq_pkg::IN_RD2];
    assign ccov_s = st_r.s2[port_seq_pkg::IN_OV1] | st_r.s2[port_seq_pkg::IN_OV2];
    assign dsov_s = st_r.s2[port_seq_pkg::IN_DSP] | st_r.s2[port_seq_pkg::IN_DSM];
    assign mode_s = st_r.s2[port_seq_pkg::IN_M0 +: 2];

    // Next-state logic for the whole sequencer
    always_comb begin
        st_nxt = st_r;

        // Two-stage synchroniser; first stage feeds only the second
        st_nxt.s1 = pins;
        st_nxt.s2 = st_r.s1;
        if (st_r.fill != port_seq_pkg::FILL_DONE) begin
            st_nxt.fill = st_r.fill + 2'h1;
        end

        // Mode changes only count once the synchroniser holds real data
        mode_chg = (st_r.fill == port_seq_pkg::FILL_DONE) && (mode_s != st_r.mode_prev);
        if (st_r.fill != port_seq_pkg::FILL_DONE) begin
            st_nxt.mode_prev = mode_s;
        end else if (mode_chg) begin
            st_nxt.mode_prev = mode_s;
        end

        // Data-line fault, fast path to the switch: follows the fault after 5 us
        if (dsov_s != st_r.sw_blk) begin
            if (st_r.sw_tmr >= port_seq_pkg::C_SW_OV - 32'h1) begin
                st_nxt.sw_blk = dsov_s;
                st_nxt.sw_tmr = '0;
            end else begin
                st_nxt.sw_tmr = st_r.sw_tmr + 32'h1;
            end
        end else begin
            st_nxt.sw_tmr = '0;
        end

        // Data-line fault, slow path to power-ok: follows after 100 us
        if (dsov_s != st_r.pg_blk) begin
            if (st_r.pg_tmr >= 32'(C_PG_OV) - 32'h1) begin
                st_nxt.pg_blk = dsov_s;
                st_nxt.pg_tmr = '0;
            end else begin
                st_nxt.pg_tmr = st_r.pg_tmr + 32'h1;
            end
        end else begin
            st_nxt.pg_tmr = '0;
        end

        // Bias supply: delay before closing, immediate open on loss
        if (!por_s) begin
            st_nxt.por_rdy = 1'b0;
            st_nxt.por_tmr = '0;
        end else if (!st_r.por_rdy) begin
            if (st_r.por_tmr >= 32'(C_DSW_ON) - 32'h1) begin
                st_nxt.por_rdy = 1'b1;
            end else begin
                st_nxt.por_tmr = st_r.por_tmr + 32'h1;
            end
        end

        // Any protection pulls power-ok low; regulation gives it the high level
        pg_want = fb_s && !ot_s && !st_r.pg_blk && (st_r.tc != port_seq_pkg::TC_OV)
                  && !ccov_s;
        st_nxt.pwr_ok = pg_want;

        // Reset triggers: mode change or power-ok rising edge
        rs_go     = 1'b0;
        rs_len_go = st_r.rs_len;
        if (mode_chg) begin
            rs_go = 1'b1;
            // Leaving dedicated mode is the short case, every other change the long one
            if (st_r.mode_prev == port_seq_pkg::MODE_DED) begin
                rs_len_go = 32'(C_RST_SHORT);
            end else begin
                rs_len_go = 32'(C_RST_LONG);
            end
        end else if (pg_want && !st_r.pwr_ok) begin
            rs_go     = 1'b1;
            rs_len_go = 32'(C_RST_SHORT);
        end

        // VBUS reset sequencer; a new trigger restarts the full length
        if (rs_go) begin
            st_nxt.rs     = port_seq_pkg::RS_DISCH;
            st_nxt.rs_tmr = '0;
            st_nxt.rs_len = rs_len_go;
        end else begin
            unique case (st_r.rs)
                port_seq_pkg::RS_IDLE: begin
                    st_nxt.rs_tmr = '0;
                end
                port_seq_pkg::RS_DISCH: begin
                    st_nxt.rs_tmr = st_r.rs_tmr + 32'h1;
                    // Stop discharging at vSafe0V or when the timeout runs out
                    if (safe_s || st_r.rs_tmr >= 32'(C_DIS_MAX) - 32'h1) begin
                        st_nxt.rs = port_seq_pkg::RS_HOLD;
                    end
                    if (st_r.rs_tmr >= st_r.rs_len - 32'h1) begin
                        st_nxt.rs = port_seq_pkg::RS_IDLE;
                    end
                end
                port_seq_pkg::RS_HOLD: begin
                    st_nxt.rs_tmr = st_r.rs_tmr + 32'h1;
                    if (st_r.rs_tmr >= st_r.rs_len - 32'h1) begin
                        st_nxt.rs = port_seq_pkg::RS_IDLE;
                    end
                end
                default: begin
                    st_nxt.rs = port_seq_pkg::RS_IDLE;
                end
            endcase
        end

        // Type-C port; CC over-voltage overrides every other state
        rd_sel = st_r.tc_sel ? rd2_s : rd1_s;
        if (ccov_s) begin
            st_nxt.tc     = port_seq_pkg::TC_OV;
            st_nxt.tc_tmr = '0;
        end else begin
            unique case (st_r.tc)
                port_seq_pkg::TC_UNATT: begin
                    st_nxt.tc_tmr = '0;
                    if (rd1_s || rd2_s) begin
                        st_nxt.tc     = port_seq_pkg::TC_ATT;
                        st_nxt.tc_sel = !rd1_s;
                    end
                end
                port_seq_pkg::TC_ATT: begin
                    if (!rd_sel) begin
                        st_nxt.tc = port_seq_pkg::TC_DETACH;
                    end
                end
                port_seq_pkg::TC_DETACH: begin
                    st_nxt.tc_tmr = st_r.tc_tmr + 32'h1;
                    // Re-pull at vSafe0V, or by force once the wait runs out
                    if (safe_s || st_r.tc_tmr >= 32'(C_DETACH) - 32'h1) begin
                        st_nxt.tc = port_seq_pkg::TC_UNATT;
                    end
                end
                port_seq_pkg::TC_OV: begin
                    st_nxt.tc = port_seq_pkg::TC_UNATT;
                end
                default: begin
                    st_nxt.tc = port_seq_pkg::TC_UNATT;
                end
            endcase
        end

        // Gate follows the attached state, off at once on any CC fault
        st_nxt.gate_on = (st_nxt.tc == port_seq_pkg::TC_ATT);

        // Only the attached line goes open during detach; both pull up otherwise
        st_nxt.cc1_pu = !(st_nxt.tc == port_seq_pkg::TC_DETACH && !st_nxt.tc_sel);
        st_nxt.cc2_pu = !(st_nxt.tc == port_seq_pkg::TC_DETACH && st_nxt.tc_sel);

        // Soft-start node held low during reset discharge and over-temperature
        st_nxt.ss_pull = (st_nxt.rs == port_seq_pkg::RS_DISCH) || ot_s;

        // Converter runs only when enabled, cool and outside a reset
        st_nxt.conv_en = en_s && !ot_s && (st_nxt.rs == port_seq_pkg::RS_IDLE);

        // VBUS discharge for reset, detach wait and CC fault
        st_nxt.vbus_dis = (st_nxt.rs == port_seq_pkg::RS_DISCH)
                          || (st_nxt.tc == port_seq_pkg::TC_DETACH)
                          || (st_nxt.tc == port_seq_pkg::TC_OV);

        // Data switch: bias ready, pass-through mode, no data fault
        st_nxt.dsw_on = st_nxt.por_rdy && !st_nxt.sw_blk
                        && (mode_s == port_seq_pkg::MODE_STD
                            || mode_s == port_seq_pkg::MODE_CDN);
    end

    // One register stage for all state; reset leaves everything off except both CC pull-ups, which come up on
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            st_r <= '{
                rs:      port_seq_pkg::RS_IDLE,
                tc:      port_seq_pkg::TC_UNATT,
                cc1_pu:  1'b1,
                cc2_pu:  1'b1,
                default: '0
            };
        end else begin
            st_r <= st_nxt;
        end
    end

    // Outputs come straight from the state register
    assign converter_on    = st_r.conv_en;
    assign reset_discharge = st_r.ss_pull;
    assign vbus_discharge  = st_r.vbus_dis;
    assign power_ok_output = st_r.pwr_ok;
    assign data_switch_on  = st_r.dsw_on;
    assign vbus_gate_on    = st_r.gate_on;
    assign cc1_pullup_on   = st_r.cc1_pu;
    assign cc2_pullup_on   = st_r.cc2_pu;

endmodule

// >>> test/usb_port_power_sequencer_monitor.sv
module usb_port_power_sequencer_monitor #(
    parameter int unsigned C_DETACH = 60
) (
    input wire logic       clk_sys,
    input wire logic       rst,
    input wire logic       enable,
    input wire logic       bias_por_ok,
    input wire logic       power_ok_rise_threshold,
    input wire logic       vbus_sense_pin,
    input wire logic       over_temp,
    input wire logic       cc1_sink_seen,
    input wire logic       cc2_sink_seen,
    input wire logic       cc1_over_volt,
    input wire logic       cc2_over_volt,
    input wire logic       data_side_plus,
    input wire logic       data_side_minus,
    input wire logic [1:0] charging_mode_select,
    input wire logic       converter_on,
    input wire logic       reset_discharge,
    input wire logic       vbus_discharge,
    input wire logic       power_ok_output,
    input wire logic       data_switch_on,
    input wire logic       vbus_gate_on,
    input wire logic       cc1_pullup_on,
    input wire logic       cc2_pullup_on
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    logic        sink_any;  // Either CC line loaded
    logic        ccov;      // Either CC line over-voltage
    logic [3:0]  up_r;      // Cycles since reset, saturating
    logic [31:0] open_r;    // Cycles a pull-up stood open while unattached
    assign sink_any = cc1_sink_seen | cc2_sink_seen;
    assign ccov     = cc1_over_volt | cc2_over_volt;
    // Helper counters; open time restarts while attached or in CC fault
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            up_r   <= 4'h0;
            open_r <= 32'h0;
        end else begin
            if (up_r != 4'hf) up_r <= up_r + 4'h1;
            if ((cc1_pullup_on && cc2_pullup_on) || ccov || vbus_gate_on) open_r <= 32'h0;
            else open_r <= open_r + 32'h1;
        end
    end
    property p_hot; over_temp [*6] |-> !converter_on && !power_ok_output; endproperty
    a_hot: assert property (p_hot) else $error("converter running while hot");
    property p_ccov; ccov [*6] |-> !vbus_gate_on && !power_ok_output; endproperty
    a_ccov: assert property (p_ccov) else $error("gate or power ok on in CC fault");
    property p_ccdis; $rose(ccov) |-> ##[2:6] vbus_discharge; endproperty
    a_ccdis: assert property (p_ccdis) else $error("no discharge on CC fault");
    property p_mode; up_r == 4'hf && $changed(charging_mode_select) |-> ##[2:6] reset_discharge; endproperty
    a_mode: assert property (p_mode) else $error("mode change without discharge");
    property p_ded; charging_mode_select == port_seq_pkg::MODE_DED [*6] |-> !data_switch_on; endproperty
    a_ded: assert property (p_ded) else $error("switch closed in dedicated mode");
    property p_bias; !bias_por_ok [*6] |-> !data_switch_on; endproperty
    a_bias: assert property (p_bias) else $error("switch closed without bias");
    property p_pg; !power_ok_rise_threshold [*6] |-> !power_ok_output; endproperty
    a_pg: assert property (p_pg) else $error("power ok without regulation");
    property p_gate; $rose(vbus_gate_on) |-> $past(sink_any, 3); endproperty
    a_gate: assert property (p_gate) else $error("gate on without sink");
    property p_open; open_r <= 32'(C_DETACH) + 32'h8; endproperty
    a_open: assert property (p_open) else $error("pull-up open too long");
    c_attach: cover property ($rose(vbus_gate_on));
    c_reset: cover property ($rose(reset_discharge));
    c_dov: cover property ($fell(data_switch_on) && bias_por_ok);
endmodule

bind usb_port_power_sequencer usb_port_power_sequencer_monitor #(.C_DETACH(C_DETACH)) usb_port_power_sequencer_monitor_i (
    .clk_sys, .rst, .enable, .bias_por_ok, .power_ok_rise_threshold, .vbus_sense_pin, .over_temp,
    .cc1_sink_seen, .cc2_sink_seen, .cc1_over_volt, .cc2_over_volt, .data_side_plus, .data_side_minus,
    .charging_mode_select, .converter_on, .reset_discharge, .vbus_discharge, .power_ok_output,
    .data_switch_on, .vbus_gate_on, .cc1_pullup_on, .cc2_pullup_on);

// >>> test/usb_port_partner.sv
module usb_port_partner (
    input  wire logic        clk_sys,
    input  wire logic [1:0]  plug,            // Bit 0 loads CC1, bit 1 loads CC2
    input  wire logic [15:0] fall_cyc,        // Cycles to bleed to vSafe0V, 0 means never
    input  wire logic        vbus_discharge,
    input  wire logic        converter_on,
    output logic             cc1_sink_seen,
    output logic             cc2_sink_seen,
    output logic             vbus_sense_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    int lvl = 10;  // Remaining charge on the bus, in cycles
    // Sink termination follows the plug
    assign cc1_sink_seen = plug[0];
    assign cc2_sink_seen = plug[1];
    // Bus bleeds while discharged; a stuck load never reaches safe level
    always @(posedge clk_sys) begin
        if (vbus_discharge && lvl > 0) lvl <= lvl - 1;
        else if (!vbus_discharge && converter_on) lvl <= (fall_cyc == 16'h0000) ? 1000000 : int'(fall_cyc);
        vbus_sense_pin <= (lvl == 0);
    end
endmodule

// >>> test/usb_port_power_sequencer_bench.sv
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin num_errors++; \
    $display("wrong value at %0t: %0d not %0d", $time, got, exp); end end

module usb_port_power_sequencer_bench;
    timeunit 1ns;
    timeprecision 1ps;
    // Shortened counts; switch delay on data fault is fixed
    localparam int CS = 40, CL = 200, CD = 150, CT = 60, CW = 20, CP = 30, SW = 1250;
    logic        clk_sys = 1'b0, rst = 1'b1, enable = 1'b1, bias_por_ok = 1'b0, over_temp = 1'b0;
    logic        power_ok_rise_threshold = 1'b0, cc1_over_volt = 1'b0, cc2_over_volt = 1'b0;
    logic        data_side_plus = 1'b0, data_side_minus = 1'b0, cc1_sink_seen, cc2_sink_seen, vbus_sense_pin;
    logic [1:0]  charging_mode_select = 2'h0, plug = 2'h0, prev;
    logic [15:0] fall_cyc = 16'h000a;
    logic        converter_on, reset_discharge, vbus_discharge, power_ok_output;
    logic        data_switch_on, vbus_gate_on, cc1_pullup_on, cc2_pullup_on;
    logic [7:0]  lfsr = 8'h35;  // Random source, seed 53
    logic [1:0]  seq[$] = '{2'h1, 2'h2, 2'h0, 2'h2, 2'h1, 2'h0};  // Visits all six transitions
    int          num_errors = 0, n_compared = 0, n, t, k, e;
    wire  [7:0]  outs = {cc2_pullup_on, cc1_pullup_on, vbus_gate_on, data_switch_on,
                         power_ok_output, vbus_discharge, reset_discharge, converter_on};

    usb_port_power_sequencer #(.C_RST_SHORT(CS), .C_RST_LONG(CL), .C_DIS_MAX(CD), .C_DETACH(CT),
        .C_DSW_ON(CW), .C_PG_OV(CP)) usb_port_power_sequencer_i (.clk_sys, .rst, .enable, .bias_por_ok,
        .power_ok_rise_threshold, .vbus_sense_pin, .over_temp, .cc1_sink_seen, .cc2_sink_seen,
        .cc1_over_volt, .cc2_over_volt, .data_side_plus, .data_side_minus, .charging_mode_select,
        .converter_on, .reset_discharge, .vbus_discharge, .power_ok_output, .data_switch_on,
        .vbus_gate_on, .cc1_pullup_on, .cc2_pullup_on);
    usb_port_partner usb_port_partner_i (.clk_sys, .plug, .fall_cyc, .vbus_discharge, .converter_on,
        .cc1_sink_seen, .cc2_sink_seen, .vbus_sense_pin);

    // Clock, 4 ns period
    initial begin
        forever #2 clk_sys = ~clk_sys;
    end

    function automatic logic [7:0] nx(input logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction

    // Counts falling edges until an output reaches a level, bounded
    task automatic wait_out(input int idx, input logic lvl, input int lim);
        n = 0;
        while (outs[idx] !== lvl && n < lim) begin
            @(negedge clk_sys);
            n++;
        end
    endtask

    task automatic finish_test();
        $display("compared %0d, mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    // Watchdog well past the expected run length
    initial begin
        repeat (30000) @(posedge clk_sys);
        num_errors++;
        finish_test();
    end

    initial begin
        repeat (10) @(negedge clk_sys);
        `CHK(outs, 8'hc0)
        rst = 1'b0;
        bias_por_ok = 1'b1;
        wait_out(4, 1'b1, 100);
        `CHK(n >= CW && n <= CW + 8, 1'b1)
        $display("bias start done");
        // Model: short reset only when leaving dedicated mode
        prev = 2'h0;
        foreach (seq[i]) begin
            charging_mode_select = seq[i];
            wait_out(1, 1'b1, 10);
            `CHK(n >= 1 && n <= 8, 1'b1)
            t = n;
            wait_out(0, 1'b1, 400);
            e = (prev == 2'h2) ? CS : CL;
            `CHK(t + n >= e && t + n <= e + 8, 1'b1)
            `CHK(data_switch_on, seq[i] != 2'h2)
            prev = seq[i];
        end
        $display("mode changes done");
        fall_cyc = 16'h0000;
        // Let the bus recharge so a stale safe level cannot end the discharge early
        repeat (8) @(negedge clk_sys);
        charging_mode_select = 2'h1;
        wait_out(2, 1'b1, 10);
        wait_out(2, 1'b0, 400);
        `CHK(n >= CD - 3 && n <= CD + 3, 1'b1)
        `CHK(converter_on, 1'b0)
        wait_out(0, 1'b1, 400);
        fall_cyc = 16'h000a;
        power_ok_rise_threshold = 1'b1;
        wait_out(3, 1'b1, 10);
        wait_out(0, 1'b0, 8);
        wait_out(0, 1'b1, 200);
        `CHK(n >= CS - 3 && n <= CS + 3, 1'b1)
        $display("timeout and power ok reset done");
        lfsr = nx(lfsr);
        if (lfsr[0]) data_side_plus = 1'b1;
        else data_side_minus = 1'b1;
        wait_out(3, 1'b0, 100);
        `CHK(n >= CP && n <= CP + 8, 1'b1)
        t = n;
        wait_out(4, 1'b0, 1400);
        `CHK(t + n >= SW && t + n <= SW + 8, 1'b1)
        data_side_plus = 1'b0;
        data_side_minus = 1'b0;
        wait_out(3, 1'b1, 100);
        `CHK(n >= CP && n <= CP + 8, 1'b1)
        t = n;
        wait_out(0, 1'b0, 8);
        `CHK(n <= 4, 1'b1)
        t += n;
        wait_out(4, 1'b1, 1400);
        `CHK(t + n >= SW && t + n <= SW + 8, 1'b1)
        wait_out(0, 1'b1, 200);
        $display("data fault done");
        // Attach on a random line, detach with prompt and with stuck bus
        for (int r = 0; r < 2; r++) begin
            lfsr = nx(lfsr);
            k = lfsr[0];
            plug = k ? 2'h2 : 2'h1;
            wait_out(5, 1'b1, 10);
            `CHK(n >= 1 && n <= 6, 1'b1)
            fall_cyc = r ? 16'h0000 : 16'h000a;
            repeat (4) @(negedge clk_sys);
            plug = 2'h0;
            wait_out(6 + k, 1'b0, 10);
            `CHK(n >= 1 && n <= 6, 1'b1)
            `CHK(vbus_gate_on, 1'b0)
            wait_out(6 + k, 1'b1, 200);
            e = r ? CT : 12;
            `CHK(n >= e - 3 && n <= e + 6, 1'b1)
        end
        fall_cyc = 16'h000a;
        $display("attach and detach done");
        plug = 2'h1;
        wait_out(5, 1'b1, 10);
        cc2_over_volt = 1'b1;
        wait_out(5, 1'b0, 10);
        `CHK(n >= 1 && n <= 6, 1'b1)
        `CHK(power_ok_output, 1'b0)
        `CHK(vbus_discharge, 1'b1)
        cc2_over_volt = 1'b0;
        wait_out(3, 1'b1, 12);
        `CHK(n >= 1 && n <= 8, 1'b1)
        wait_out(5, 1'b1, 12);
        `CHK(vbus_gate_on, 1'b1)
        plug = 2'h0;
        $display("CC fault done");
        wait_out(0, 1'b1, 300);
        over_temp = 1'b1;
        wait_out(3, 1'b0, 10);
        `CHK(n >= 1 && n <= 6, 1'b1)
        `CHK(converter_on, 1'b0)
        over_temp = 1'b0;
        wait_out(0, 1'b1, 300);
        `CHK(converter_on, 1'b1)
        bias_por_ok = 1'b0;
        wait_out(4, 1'b0, 10);
        `CHK(n >= 1 && n <= 6, 1'b1)
        $display("thermal and bias loss done");
        finish_test();
    end
endmodule
